/* File: pkg/fscc_pkg.sv */
// Constants, state encodings and carrier types of the fail-safe clock switch control.
//
// Behaviour
// - Monitor/switch select field 1x disables both switching and monitoring; default setting.
// - With monitoring on, low-power RC runs except in Sleep, ignoring watchdog enable.
// - A detected failure raises a trap and moves the system clock to fast RC.
// - On failure: current group gets fast RC, clock-fail flag sets, switch enable clears.
// - A clock failure leaves the watchdog's low-power RC clock untouched.
// - Power-up timer expiring before the oscillator starts also traps to fast RC.
// - Sources form four groups; switching is between groups, never inside one.
// - The primary group's oscillator choice comes from the primary configuration field.
// - The current-group field is read-only and reports the group in effect.
// - Software writes the new-group field; it is the destination of a switch.
// - After reset both current and new group load from the group configuration.
// - Status bits show PLL lock and, read-only, whether a clock failure occurred.
// - Switch enable set starts a transition; clearing it aborts the transition.
// - With switching off, configuration selects directly; current group only reports it.
// - Low byte unlocks only by consecutive byte writes 0x46 then 0x57.
// - High byte unlocks only by consecutive byte writes 0x78 then 0x9A.
// - After unlock, one write to that byte is accepted in the next cycle only.
// - Lock status sits at bit 5; PLL in use with the primary group current holds the clock until locked.
`default_nettype none

package fscc_pkg;

  localparam logic [1:0] GRP_FRC       = 2'h0;
  localparam logic [1:0] GRP_LOW_POWER_RC_OSC      = 2'h1;
  localparam logic [1:0] GRP_SECONDARY = 2'h2;
  localparam logic [1:0] GRP_PRIMARY   = 2'h3;

  localparam int         MSS_OFF_BIT   = 1;
  localparam logic [1:0] MSS_MON_ON    = 2'h0;

  localparam logic       ADDR_LOW      = 1'b0;
  localparam logic       ADDR_HIGH     = 1'b1;

  localparam int         BIT_SWITCH_ENABLE_BIT     = 0;
  localparam int         BIT_CF        = 3;
  localparam int         BIT_LOCK      = 5;
  localparam int         NOSC_LSB      = 8;
  localparam int         COSC_LSB      = 12;

  localparam logic [7:0] KEY_LOW_1     = 8'h46;
  localparam logic [7:0] KEY_LOW_2     = 8'h57;
  localparam logic [7:0] KEY_HIGH_1    = 8'h78;
  localparam logic [7:0] KEY_HIGH_2    = 8'h9A;

  localparam logic [15:0] REG_RESET    = 16'h0000;
  localparam int          FAIL_TICKS   = 4;

  typedef enum logic [1:0] {
    UL_IDLE  = 2'b00,
    UL_FIRST = 2'b01,
    UL_OPEN  = 2'b10
  } fscc_ul_state_t;

  typedef enum logic [0:0] {
    SW_IDLE = 1'b0,
    SW_WAIT = 1'b1
  } fscc_sw_state_t;

  typedef struct packed {
    logic       addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fscc_bus_req_t;

  typedef struct packed {
    logic [1:0] monitor_switch_select_cfg;
    logic [1:0] osc_group_cfg;
    logic [3:0] primary_osc_cfg;
  } fscc_cfg_t;

endpackage

`default_nettype wire

/* File: logic/fscc_unlock.sv */
// Two-key unlock sequencer that opens a one-cycle write window for one register byte.
`timescale 1ns/100ps
`default_nettype none

module fscc_unlock #(
  parameter logic [7:0] KEY1 = 8'h00,
  parameter logic [7:0] KEY2 = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       wr_this,
  input  wire logic [7:0] wdata,
  output logic            open
);
  import fscc_pkg::*;

  fscc_ul_state_t st_q;
  fscc_ul_state_t st_d;

  always_comb begin
    st_d = UL_IDLE;
    case (st_q)
      UL_IDLE: begin
        if (wr_this && wdata == KEY1) begin
          st_d = UL_FIRST;
        end
      end
      UL_FIRST: begin
        if (wr_this && wdata == KEY2) begin
          st_d = UL_OPEN;
        end else if (wr_this && wdata == KEY1) begin
          st_d = UL_FIRST;
        end
      end
      default: st_d = UL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= UL_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign open = (st_q == UL_OPEN);

  a_ul_key_order:
    assert property (@(posedge clk) disable iff (!rst_n)
      open |-> $past(st_q) == UL_FIRST && $past(wr_this) && $past(wdata) == KEY2)
    else $error("Unlock window opened without the second key.");

  a_ul_one_cycle:
    assert property (@(posedge clk) disable iff (!rst_n) open |=> !open)
    else $error("Unlock window stayed open longer than one cycle.");

endmodule

`default_nettype wire

/* File: logic/fscc_clk_monitor.sv */
// Oscillator watchdog that flags a missing clock edge or a late oscillator start.
`timescale 1ns/100ps
`default_nettype none

module fscc_clk_monitor #(
  parameter int FAIL_TICKS_P = fscc_pkg::FAIL_TICKS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic active,
  input  wire logic low_power_rc_osc_tick,
  input  wire logic osc_edge,
  input  wire logic power_up_timer_done,
  input  wire logic osc_started,
  output logic      fail_q
);
  import fscc_pkg::*;

  logic [7:0] cnt_q;
  logic       timeout;
  logic       late_start;

  // Low-power RC ticks without an oscillator edge.
  assign timeout    = active && low_power_rc_osc_tick && !osc_edge && cnt_q == 8'(FAIL_TICKS_P - 1);
  assign late_start = active && power_up_timer_done && !osc_started;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (!active || osc_edge || timeout) begin
      cnt_q <= 8'h00;
    end else if (low_power_rc_osc_tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_q <= 1'b0;
    end else begin
      fail_q <= timeout || late_start;
    end
  end

  a_mon_timeout:
    assert property (@(posedge clk) disable iff (!rst_n)
      (active && low_power_rc_osc_tick && !osc_edge && cnt_q == 8'(FAIL_TICKS_P - 1)) |=> fail_q)
    else $error("Missing clock edge was not flagged.");

endmodule

`default_nettype wire

/* File: logic/fscc_top.sv */
// Fail-safe clock monitor and oscillator group switch with guarded control register.
`timescale 1ns/100ps
`default_nettype none

module fscc_top #(
  parameter int FAIL_TICKS_P = fscc_pkg::FAIL_TICKS
) (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire fscc_pkg::fscc_bus_req_t bus,
  input  wire fscc_pkg::fscc_cfg_t     cfg,
  input  wire logic                  low_power_rc_osc_tick,
  input  wire logic                  osc_edge,
  input  wire logic                  power_up_timer_done,
  input  wire logic                  osc_started,
  input  wire logic [3:0]            grp_ready,
  input  wire logic                  pll_in_use,
  input  wire logic                  pll_lock,
  input  wire logic                  sleep_mode,
  input  wire logic                  software_watchdog_enable,
  output logic [7:0]                 rdata_q,
  output logic [1:0]                 current_osc_group_q,
  output logic [3:0]                 primary_sel_q,
  output logic                       fail_trap_q,
  output logic                       low_power_rc_osc_enable_q,
  output logic                       clk_hold_q
);
  import fscc_pkg::*;

  logic           rst_s1_q;
  logic           rst_n_q;
  logic           init_q;
  logic [1:0]     nosc_q;
  logic           switch_enable_bit_q;
  logic           cf_q;
  logic           lock_q;
  fscc_sw_state_t sw_st_q;
  logic           sw_en;
  logic           mon_en;
  logic           mon_act;
  logic           mon_fail;
  logic           wr_lo;
  logic           wr_hi;
  logic           lo_open;
  logic           hi_open;
  logic           wr_lo_ok;
  logic           wr_hi_ok;
  logic           target_ok;
  logic           commit;
  logic [15:0]    img;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // Select field 1x turns both functions off.
  assign sw_en  = !cfg.monitor_switch_select_cfg[MSS_OFF_BIT];
  assign mon_en = (cfg.monitor_switch_select_cfg == MSS_MON_ON);

  assign mon_act = mon_en && !sleep_mode && !init_q && current_osc_group_q != GRP_FRC;

  assign wr_lo    = bus.wr && bus.addr == ADDR_LOW;
  assign wr_hi    = bus.wr && bus.addr == ADDR_HIGH;
  // Only writes inside the window land.
  assign wr_lo_ok = wr_lo && lo_open;
  assign wr_hi_ok = wr_hi && hi_open;

  fscc_unlock #(
    .KEY1 (KEY_LOW_1),
    .KEY2 (KEY_LOW_2)
  ) u_unlock_low (
    .clk     (clk),
    .rst_n   (rst_n_q),
    .wr_this (wr_lo),
    .wdata   (bus.wdata),
    .open    (lo_open)
  );

  fscc_unlock #(
    .KEY1 (KEY_HIGH_1),
    .KEY2 (KEY_HIGH_2)
  ) u_unlock_high (
    .clk     (clk),
    .rst_n   (rst_n_q),
    .wr_this (wr_hi),
    .wdata   (bus.wdata),
    .open    (hi_open)
  );

  fscc_clk_monitor #(
    .FAIL_TICKS_P (FAIL_TICKS_P)
  ) u_monitor (
    .clk         (clk),
    .rst_n       (rst_n_q),
    .active      (mon_act),
    .low_power_rc_osc_tick   (low_power_rc_osc_tick),
    .osc_edge    (osc_edge),
    .power_up_timer_done   (power_up_timer_done),
    .osc_started (osc_started),
    .fail_q      (mon_fail)
  );

  // Primary with PLL waits for lock.
  assign target_ok = grp_ready[nosc_q] && !(nosc_q == GRP_PRIMARY && pll_in_use && !pll_lock);
  assign commit    = sw_st_q == SW_WAIT && switch_enable_bit_q && target_ok && sw_en && !mon_fail;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // Start on set, abort on clear.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sw_st_q <= SW_IDLE;
    end else begin
      case (sw_st_q)
        SW_IDLE: begin
          if (switch_enable_bit_q && sw_en && !mon_fail) begin
            sw_st_q <= SW_WAIT;
          end
        end
        SW_WAIT: begin
          if (!switch_enable_bit_q || mon_fail || commit || !sw_en) begin
            sw_st_q <= SW_IDLE;
          end
        end
        default: sw_st_q <= SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      switch_enable_bit_q <= REG_RESET[BIT_SWITCH_ENABLE_BIT];
    end else if (mon_fail || commit) begin
      switch_enable_bit_q <= 1'b0;
    end else if (wr_lo_ok) begin
      switch_enable_bit_q <= bus.wdata[BIT_SWITCH_ENABLE_BIT] && sw_en;
    end
  end

  // Current group: reset load, failure, fixed or switched.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      current_osc_group_q <= GRP_FRC;
    end else if (init_q) begin
      current_osc_group_q <= cfg.osc_group_cfg;
    end else if (mon_fail) begin
      current_osc_group_q <= GRP_FRC;
    end else if (!sw_en) begin
      current_osc_group_q <= cfg.osc_group_cfg;
    end else if (commit) begin
      current_osc_group_q <= nosc_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nosc_q <= GRP_FRC;
    end else if (init_q) begin
      nosc_q <= cfg.osc_group_cfg;
    end else if (wr_hi_ok) begin
      nosc_q <= bus.wdata[NOSC_LSB - 8 +: 2];
    end
  end

  // Sticky failure flag and lock status.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cf_q   <= REG_RESET[BIT_CF];
      lock_q <= REG_RESET[BIT_LOCK];
    end else begin
      cf_q   <= cf_q || mon_fail;
      lock_q <= pll_lock;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fail_trap_q   <= 1'b0;
      primary_sel_q <= 4'h0;
      low_power_rc_osc_enable_q <= 1'b0;
      clk_hold_q    <= 1'b0;
    end else begin
      fail_trap_q   <= mon_fail;
      primary_sel_q <= cfg.primary_osc_cfg;
      low_power_rc_osc_enable_q <= mon_en ? !sleep_mode : software_watchdog_enable;
      clk_hold_q    <= current_osc_group_q == GRP_PRIMARY && pll_in_use && !pll_lock;
    end
  end

  always_comb begin
    img                       = REG_RESET;
    img[BIT_SWITCH_ENABLE_BIT]            = switch_enable_bit_q;
    img[BIT_CF]               = cf_q;
    img[BIT_LOCK]             = lock_q;
    img[NOSC_LSB +: 2]        = nosc_q;
    img[COSC_LSB +: 2]        = current_osc_group_q;
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else if (bus.rd && bus.addr == ADDR_LOW) begin
      rdata_q <= img[7:0];
    end else if (bus.rd && bus.addr == ADDR_HIGH) begin
      rdata_q <= img[15:8];
    end else begin
      rdata_q <= 8'h00;
    end
  end

  a_cfg_off_mon:
    assert property (@(posedge clk) disable iff (!rst_n_q) !mon_en |=> !mon_fail)
    else $error("Monitor fired while disabled.");

  a_cfg_off_sw:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (!sw_en && !switch_enable_bit_q) |=> !switch_enable_bit_q)
    else $error("Switch enable set while switching disabled.");

  a_low_power_rc_osc_alive:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (mon_en && !sleep_mode && !init_q) |=> low_power_rc_osc_enable_q)
    else $error("Low-power RC stopped while monitoring.");

  a_fail_to_frc:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      mon_fail |=> fail_trap_q && current_osc_group_q == GRP_FRC)
    else $error("Failure did not trap to fast RC.");

  a_fail_fields:
    assert property (@(posedge clk) disable iff (!rst_n_q) mon_fail |=> cf_q && !switch_enable_bit_q)
    else $error("Failure did not set flag and clear switch enable.");

  a_wdt_clock:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      mon_fail |=> low_power_rc_osc_enable_q == ($past(mon_en) ? !$past(sleep_mode)
                                                   : $past(software_watchdog_enable)))
    else $error("Failure disturbed the watchdog clock.");

  a_late_start:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (mon_act && power_up_timer_done && !osc_started) |=> mon_fail ##1 current_osc_group_q == GRP_FRC)
    else $error("Late oscillator start did not trap.");

  a_cosc_ro:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (bus.wr && !init_q && !mon_fail && !commit && sw_en) |=> $stable(current_osc_group_q))
    else $error("Software write changed the current group.");

  a_nosc_write:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (wr_hi_ok && !init_q) |=> nosc_q == $past(bus.wdata[1:0]))
    else $error("New group write not stored.");

  a_reset_load:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (init_q && rst_n_q) |=>
        current_osc_group_q == $past(cfg.osc_group_cfg) && nosc_q == current_osc_group_q)
    else $error("Groups not loaded from configuration.");

  a_switch_done:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      commit |=> current_osc_group_q == $past(nosc_q) && !switch_enable_bit_q && sw_st_q == SW_IDLE)
    else $error("Switch did not complete.");

  a_switch_abort:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (sw_st_q == SW_WAIT && !switch_enable_bit_q) |=> sw_st_q == SW_IDLE ##1 sw_st_q == SW_IDLE)
    else $error("Cleared switch enable did not abort.");

  a_fixed_sel:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (!sw_en && !init_q && !mon_fail) |=> current_osc_group_q == $past(cfg.osc_group_cfg))
    else $error("Group not following configuration.");

  a_pll_hold:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (sw_st_q == SW_WAIT && nosc_q == GRP_PRIMARY && pll_in_use && !pll_lock) |-> !commit)
    else $error("Switched to primary before PLL lock.");

  a_locked_write:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (wr_lo && !lo_open && !mon_fail && !commit) |=> $stable(switch_enable_bit_q))
    else $error("Locked low byte accepted a write.");

  a_cf_sticky:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      cf_q |=> cf_q)
    else $error("Clock-fail flag cleared without reset.");

  a_lock_status:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      !init_q |=> lock_q == $past(pll_lock))
    else $error("Lock status does not follow the PLL.");

  a_rdata_idle:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      !bus.rd |=> rdata_q == 8'h00)
    else $error("Read data not zero outside a read.");

  a_rdata_cosc:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (bus.rd && bus.addr == ADDR_HIGH) |=>
        rdata_q[COSC_LSB - 8 +: 2] == $past(current_osc_group_q))
    else $error("High byte read does not show the current group.");

  a_hold_pll:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (current_osc_group_q == GRP_PRIMARY && pll_in_use && !pll_lock) |=> clk_hold_q)
    else $error("Clock not held while the PLL is unlocked.");

  a_primary_sel:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      !init_q |=> primary_sel_q == $past(cfg.primary_osc_cfg))
    else $error("Primary choice not taken from configuration.");

  a_switch_enable_bit_rise:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      $rose(switch_enable_bit_q) |-> $past(wr_lo_ok))
    else $error("Switch enable set without an unlocked write.");

  a_frc_quiet:
    assert property (@(posedge clk) disable iff (!rst_n_q)
      (current_osc_group_q == GRP_FRC) |=> !mon_fail)
    else $error("Failure flagged while running on fast RC.");

endmodule

`default_nettype wire

/* File: bench/fscc_osc_model.sv */
// Model of the oscillator sources: oscillator edges, low-power RC ticks and power-up timer.
`timescale 1ns/100ps
`default_nettype none

module fscc_osc_model #(
  parameter int LOW_POWER_RC_OSC_DIV = 32,
  parameter int POWER_UP_TIMER_CYC = 6
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       lock_en,
  input  wire logic [3:0] ready_en,
  output logic            low_power_rc_osc_tick,
  output logic            osc_edge,
  output logic            power_up_timer_done,
  output logic            osc_started,
  output logic            pll_lock,
  output logic [3:0]      grp_ready
);
  int low_power_rc_osc_cnt;
  int edge_cnt;
  int power_up_timer_cnt;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_power_rc_osc_cnt    <= 0;
      edge_cnt    <= 0;
      power_up_timer_cnt    <= 0;
      low_power_rc_osc_tick   <= 1'b0;
      osc_edge    <= 1'b0;
      power_up_timer_done   <= 1'b0;
      osc_started <= 1'b0;
      pll_lock    <= 1'b0;
      grp_ready   <= 4'h0;
    end else begin
      low_power_rc_osc_cnt    <= (low_power_rc_osc_cnt == LOW_POWER_RC_OSC_DIV - 1) ? 0 : low_power_rc_osc_cnt + 1;
      low_power_rc_osc_tick   <= (low_power_rc_osc_cnt == LOW_POWER_RC_OSC_DIV - 1);
      edge_cnt    <= edge_cnt + 1;
      osc_edge    <= run && (edge_cnt[1:0] == 2'h3);
      if (power_up_timer_cnt <= POWER_UP_TIMER_CYC) power_up_timer_cnt <= power_up_timer_cnt + 1;
      power_up_timer_done   <= (power_up_timer_cnt == POWER_UP_TIMER_CYC);
      osc_started <= run;
      pll_lock    <= lock_en;
      grp_ready   <= ready_en;
    end
  end
endmodule

`default_nettype wire

/* File: bench/fscc_top_test.sv */
// Self-checking testbench of the fail-safe clock switch control.
`timescale 1ns/100ps
`default_nettype none

module fscc_top_test;
  import fscc_pkg::*;

  logic          clk;
  logic          rst_b;
  fscc_bus_req_t bus;
  fscc_cfg_t     cfg;
  logic          low_power_rc_osc_tick, osc_edge, power_up_timer_done, osc_started, pll_lock;
  logic [3:0]    grp_ready, ready_en;
  logic          pll_in_use, sleep_mode, software_watchdog_enable, run, lock_en;
  logic [7:0]    rdata_q;
  logic [1:0]    current_osc_group_q;
  logic [3:0]    primary_sel_q;
  logic          fail_trap_q, low_power_rc_osc_enable_q, clk_hold_q;
  int            n_fail, total_checks;
  int            n_trap = 0;

  fscc_osc_model model_u (.clk(clk), .rst_b(rst_b), .run(run), .lock_en(lock_en),
    .ready_en(ready_en), .low_power_rc_osc_tick(low_power_rc_osc_tick), .osc_edge(osc_edge),
    .power_up_timer_done(power_up_timer_done), .osc_started(osc_started), .pll_lock(pll_lock),
    .grp_ready(grp_ready));

  fscc_top #(.FAIL_TICKS_P(2)) dut_u (.clk(clk), .rst_b(rst_b), .bus(bus), .cfg(cfg),
    .low_power_rc_osc_tick(low_power_rc_osc_tick), .osc_edge(osc_edge), .power_up_timer_done(power_up_timer_done),
    .osc_started(osc_started), .grp_ready(grp_ready), .pll_in_use(pll_in_use),
    .pll_lock(pll_lock), .sleep_mode(sleep_mode),
    .software_watchdog_enable(software_watchdog_enable), .rdata_q(rdata_q),
    .current_osc_group_q(current_osc_group_q), .primary_sel_q(primary_sel_q),
    .fail_trap_q(fail_trap_q), .low_power_rc_osc_enable_q(low_power_rc_osc_enable_q), .clk_hold_q(clk_hold_q));

  always #4 clk = ~clk;

  always @(posedge clk) begin
    if (fail_trap_q === 1'b1) n_trap <= n_trap + 1;
  end

  task automatic summarize();
    $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd(input logic a, input logic [7:0] exp, input string what);
    @(posedge clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 check(what, rdata_q, exp);
  endtask

  // Back-to-back byte writes to one byte, one per cycle.
  task automatic wseq(input logic a, input logic [7:0] q[$]);
    @(posedge clk);
    bus.wr   <= 1'b1;
    bus.addr <= a;
    foreach (q[i]) begin
      if (i > 0) @(posedge clk);
      bus.wdata <= q[i];
    end
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic wait_until(input logic trap, input logic [1:0] g);
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (trap ? fail_trap_q === 1'b1 : current_osc_group_q === g) return;
    end
    $display("ERROR timeout waiting, trap %b group %h", trap, g);
    n_fail++;
    summarize();
  endtask

  task automatic quiet(input string what);
    int b;
    b = n_trap;
    repeat (150) @(posedge clk);
    check(what, 16'(n_trap - b), 16'h0000);
  endtask

  task automatic do_reset(input logic [1:0] mss, input logic [1:0] grp);
    @(posedge clk);
    rst_b                         <= 1'b0;
    cfg.monitor_switch_select_cfg <= mss;
    cfg.osc_group_cfg             <= grp;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  initial begin
    int b;
    clk = 0; rst_b = 0; bus = '0; cfg = '0; cfg.primary_osc_cfg = 4'h5;
    pll_in_use = 0; sleep_mode = 0; software_watchdog_enable = 0;
    run = 1; lock_en = 1; ready_en = 4'b1001; n_fail = 0; total_checks = 0;
    do_reset(2'b00, 2'h3);
    #1 check("current group", current_osc_group_q, 2'h3);
    check("primary select", primary_sel_q, 4'h5);
    check("low_power_rc_osc enable", low_power_rc_osc_enable_q, 1'b1);
    check("clock hold", clk_hold_q, 1'b0);
    rd(1, 8'h33, "high after reset");
    rd(0, 8'h20, "low after reset");
    $display("Test reset done");
    wseq(1, '{8'h03});
    wseq(1, '{8'h78});
    wseq(1, '{8'h9A, 8'h00});
    wseq(0, '{8'h57, 8'h46, 8'h01});
    rd(1, 8'h33, "high locked");
    rd(0, 8'h20, "low wrong order");
    wseq(1, '{8'h78, 8'h9A, 8'hF2, 8'h01});
    rd(1, 8'h32, "high one write");
    $display("Test unlock done");
    wseq(0, '{8'h46, 8'h57, 8'h01});
    rd(0, 8'h21, "switch pending");
    wseq(0, '{8'h46, 8'h57, 8'h00});
    @(posedge clk);
    ready_en <= 4'b1101;
    repeat (8) @(posedge clk);
    #1 check("aborted switch", current_osc_group_q, 2'h3);
    wseq(0, '{8'h46, 8'h57, 8'h01});
    wait_until(1'b0, 2'h2);
    rd(0, 8'h20, "enable after switch");
    rd(1, 8'h22, "high after switch");
    $display("Test switch done");
    @(posedge clk);
    ready_en <= 4'b0101;
    wseq(1, '{8'h78, 8'h9A, 8'h03});
    wseq(0, '{8'h46, 8'h57, 8'h01});
    @(posedge clk);
    run <= 1'b0;
    wait_until(1'b1, 2'h0);
    check("group on trap", current_osc_group_q, 2'h0);
    @(posedge clk);
    #1 check("trap pulse", fail_trap_q, 1'b0);
    check("low_power_rc_osc after fail", low_power_rc_osc_enable_q, 1'b1);
    rd(0, 8'h28, "low after fail");
    rd(1, 8'h03, "high after fail");
    quiet("trap on fast rc");
    $display("Test failure done");
    run <= 1'b1;
    do_reset(2'b00, 2'h3);
    pll_in_use <= 1'b1;
    lock_en    <= 1'b0;
    sleep_mode <= 1'b1;
    repeat (12) @(posedge clk);
    run <= 1'b0;
    #1 check("clock hold", clk_hold_q, 1'b1);
    check("low_power_rc_osc in sleep", low_power_rc_osc_enable_q, 1'b0);
    rd(0, 8'h00, "low pll unlocked");
    ready_en <= 4'hD;
    wseq(0, '{8'h46, 8'h57, 8'h01});
    repeat (4) @(posedge clk);
    rd(0, 8'h01, "switch held for lock");
    quiet("sleep no trap");
    sleep_mode <= 1'b0;
    wait_until(1'b1, 2'h0);
    $display("Test sleep done");
    for (int m = 2; m < 4; m++) begin
      lock_en    <= 1'b1;
      pll_in_use <= 1'b0;
      do_reset(2'(m), 2'h1);
      software_watchdog_enable <= 1'b0;
      repeat (3) @(posedge clk);
      #1 check("low_power_rc_osc disabled", low_power_rc_osc_enable_q, 1'b0);
      check("group disabled", current_osc_group_q, 2'h1);
      quiet("disabled no trap");
      cfg.osc_group_cfg        <= 2'h2;
      software_watchdog_enable <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check("group follows cfg", current_osc_group_q, 2'h2);
      check("low_power_rc_osc by watchdog", low_power_rc_osc_enable_q, 1'b1);
      wseq(0, '{8'h46, 8'h57, 8'h01});
      rd(0, 8'h20, "no switch enable");
    end
    $display("Test disabled done");
    @(posedge clk);
    b = n_trap;
    do_reset(2'b00, 2'h3);
    repeat (40) @(posedge clk);
    #1 check("power_up_timer trap", 16'(n_trap - b), 16'h0001);
    check("group after power_up_timer", current_osc_group_q, 2'h0);
    $display("Test power-up done");
    summarize();
  end
endmodule

`default_nettype wire
